/* File: common/rsr_consts.svh */
// rsr_consts.svh: opcodes, field positions and counts for the return and soft-reset executor
// assumes: 14-bit instruction words, 15-bit program counter, 8-bit working register
`ifndef RSR_CONSTS_SVH
`define RSR_CONSTS_SVH
`define RSR_OP_SOFT_RESET 14'h0001
`define RSR_OP_INT_RETURN 14'h0009
`define RSR_OP_SUB_RETURN 14'h0008
`define RSR_LIT_RET_HI 4'hD
`define RSR_LIT_HI_POS 10
`define RSR_IRQ_EN_BIT 7
`define RSR_RET_CYCLES 2
`define RSR_RESET_PULSE 4
`endif

/* File: common/rsr_pkg.sv */
// rsr_pkg.sv: types shared by the return and soft-reset executor
// assumes: included constants define no types
package rsr_pkg;
  typedef enum logic [1:0] {
    RSR_OP_NONE = 2'b00,
    RSR_OP_RETI = 2'b01,
    RSR_OP_RET = 2'b10,
    RSR_OP_RETL = 2'b11
  } rsr_ret_kind_t;
  typedef struct packed {
    logic pop;
    logic load_pc;
    logic set_enable;
    logic load_w;
    logic [7:0] w_val;
  } rsr_ctl_t;
endpackage

/* File: hw/rsr_reset_pulse.sv */
// rsr_reset_pulse.sv: stretches a soft-reset request into a fixed-length reset pulse
// assumes: request comes from logic on the same clock
`timescale 1ns/10ps
`include "rsr_consts.svh"
module rsr_reset_pulse #(
  parameter int PULSE_LEN = `RSR_RESET_PULSE
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic req_in,
  output logic reset_out
);
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  // load on request, count down to zero
  assign cnt_nxt = req_in ? 4'(PULSE_LEN) : ((cnt_r != 4'h0) ? cnt_r - 4'h1 : 4'h0);
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_r <= 4'h0;
      reset_out <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      reset_out <= (cnt_nxt != 4'h0);
    end
  end
endmodule

/* File: hw/rsr_exec.sv */
// rsr_exec.sv: executes soft reset, interrupt return, subroutine return and literal return
// assumes: instr_valid_in pulses once per instruction cycle with the fetched word; stack and
// register file live outside and apply the strobes given here
//
// Overview of operation
// RULE_01: soft reset fires a full device reset
// RULE_02: soft reset clears the active-low indicator flag
// RULE_03: interrupt return pops stack into PC
// RULE_04: interrupt return sets global enable bit 7
// RULE_05: each return is one word, two cycles
// RULE_06: plain return keeps enable and W unchanged
// RULE_07: literal return loads 8-bit literal into W
// RULE_08: literal return pops stack into PC
// RULE_09: second return cycle discards prefetched word
// RULE_10: no instruction here touches C, DC, Z
`timescale 1ns/10ps
`include "rsr_consts.svh"
module rsr_exec (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic instr_valid_in,
  input wire logic [13:0] instr_in,
  input wire logic [14:0] top_of_return_stack_in,
  input wire logic [7:0] interrupt_control_register_in,
  output logic stack_pop_out,
  output logic pc_load_out,
  output logic [14:0] pc_val_out,
  output logic icr_write_out,
  output logic [7:0] icr_val_out,
  output logic w_load_out,
  output logic [7:0] w_val_out,
  output logic flush_out,
  output logic status_write_out,
  output logic soft_reset_indicator_n_out,
  output logic device_reset_out
);
  rsr_pkg::rsr_ret_kind_t kind_w;
  rsr_pkg::rsr_ctl_t ctl_w;
  logic second_r;
  logic is_reset_w;
  logic accept_w;
  logic flush_w;
  logic is_iret_w;
  logic is_ret_w;
  logic is_lit_w;
  logic [7:0] literal_w;
  logic [7:0] enable_mask_w;
  logic [7:0] icr_nxt;
  logic ind_n_r;
  logic ind_n_nxt;
  logic pulse_w;

  // decode of the fetched word; a word in the flush slot is never decoded
  function automatic rsr_pkg::rsr_ret_kind_t rsr_decode(input logic [13:0] op);
    if (op == `RSR_OP_INT_RETURN) rsr_decode = rsr_pkg::RSR_OP_RETI;
    else if (op == `RSR_OP_SUB_RETURN) rsr_decode = rsr_pkg::RSR_OP_RET;
    else if (op[13:`RSR_LIT_HI_POS] == `RSR_LIT_RET_HI) rsr_decode = rsr_pkg::RSR_OP_RETL;
    else rsr_decode = rsr_pkg::RSR_OP_NONE;
  endfunction

  // instruction slot: a word arriving in a return's second cycle is refused
  assign accept_w = instr_valid_in && !second_r; // [RULE_09]
  assign flush_w = instr_valid_in && second_r; // [RULE_09]
  assign kind_w = accept_w ? rsr_decode(instr_in) : rsr_pkg::RSR_OP_NONE;
  assign is_reset_w = accept_w && (instr_in == `RSR_OP_SOFT_RESET); // [RULE_01]

  // one view per decoded kind, used by the strobes; the checks decode instr_in directly
  assign is_iret_w = (kind_w == rsr_pkg::RSR_OP_RETI);
  assign is_ret_w = (kind_w == rsr_pkg::RSR_OP_RET);
  assign is_lit_w = (kind_w == rsr_pkg::RSR_OP_RETL);

  // control strobes per return kind; all three forms pop the stack into the pc
  assign ctl_w.pop = is_iret_w || is_ret_w || is_lit_w; // [RULE_03] [RULE_06] [RULE_08]
  assign ctl_w.load_pc = ctl_w.pop;
  assign ctl_w.set_enable = is_iret_w; // [RULE_04]
  assign ctl_w.load_w = is_lit_w; // [RULE_07]
  assign literal_w = instr_in[7:0];
  assign ctl_w.w_val = literal_w; // [RULE_07]

  // interrupt control word with only the global enable bit forced high
  assign enable_mask_w = 8'h01 << `RSR_IRQ_EN_BIT;
  assign icr_nxt = interrupt_control_register_in | enable_mask_w; // [RULE_04]

  // first cycle of a return arms the flush slot; the next valid word ends it
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      second_r <= 1'b0;
    end else if (instr_valid_in) begin
      second_r <= ctl_w.pop; // [RULE_05]
    end
  end

  // stack pop and program counter load, one cycle after the return is taken
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      stack_pop_out <= 1'b0;
      pc_load_out <= 1'b0;
      pc_val_out <= 15'h0000;
    end else begin
      stack_pop_out <= ctl_w.pop; // [RULE_03] [RULE_08]
      pc_load_out <= ctl_w.load_pc;
      pc_val_out <= top_of_return_stack_in; // [RULE_03] [RULE_06] [RULE_08]
    end
  end

  // interrupt control write; only the interrupt return raises it
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      icr_write_out <= 1'b0;
      icr_val_out <= 8'h00;
    end else begin
      icr_write_out <= ctl_w.set_enable; // [RULE_04]
      icr_val_out <= icr_nxt;
    end
  end

  // working register load, for the literal return only
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      w_load_out <= 1'b0;
      w_val_out <= 8'h00;
    end else begin
      w_load_out <= ctl_w.load_w; // [RULE_07]
      w_val_out <= ctl_w.w_val;
    end
  end

  // prefetch discard marker; status flags are never written from here
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      flush_out <= 1'b0;
      status_write_out <= 1'b0;
    end else begin
      flush_out <= flush_w; // [RULE_09]
      status_write_out <= 1'b0; // [RULE_10]
    end
  end

  // indicator: cleared by soft reset, survives the device reset it causes
  assign ind_n_nxt = is_reset_w ? 1'b0 : ind_n_r; // [RULE_02]
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ind_n_r <= 1'b1;
    end else begin
      ind_n_r <= ind_n_nxt;
    end
  end
  assign soft_reset_indicator_n_out = ind_n_r;

  // stretched device reset request
  rsr_reset_pulse #(.PULSE_LEN(`RSR_RESET_PULSE)) u_pulse (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .req_in(is_reset_w), // [RULE_01]
    .reset_out(pulse_w)
  );
  assign device_reset_out = pulse_w;

  // checks on the return strobes
  pop_on_return_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RULE_06]
    (instr_valid_in && !second_r && (instr_in == `RSR_OP_SUB_RETURN))
    |=> (stack_pop_out && pc_load_out && !w_load_out && !icr_write_out))
    else $error("plain return wrong strobes");
  iret_strobes_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RULE_03]
    (accept_w && (instr_in == `RSR_OP_INT_RETURN))
    |=> (stack_pop_out && pc_load_out && icr_write_out && !w_load_out))
    else $error("interrupt return wrong strobes");
  enable_on_iret_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RULE_04]
    icr_write_out |-> (icr_val_out[`RSR_IRQ_EN_BIT] && pc_load_out))
    else $error("interrupt return did not set enable");
  iret_value_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RULE_04]
    icr_write_out |-> (icr_val_out == ($past(interrupt_control_register_in) | 8'h80)))
    else $error("interrupt control word altered beyond enable bit");
  pc_from_stack_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RULE_03]
    pc_load_out |-> (pc_val_out == $past(top_of_return_stack_in)))
    else $error("pc not loaded from stack top");
  pc_with_pop_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RULE_03]
    pc_load_out |-> stack_pop_out)
    else $error("pc load without stack pop");

  // checks on the literal return
  lit_to_w_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RULE_07]
    (accept_w && (instr_in[13:`RSR_LIT_HI_POS] == `RSR_LIT_RET_HI))
    |=> (w_load_out && (w_val_out == $past(literal_w)) && stack_pop_out))
    else $error("literal return wrong");
  lit_pops_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RULE_08]
    w_load_out |-> pc_load_out)
    else $error("literal return without pc load");

  // checks on the two-cycle timing, the discarded prefetch and the status flags
  flush_second_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RULE_09]
    (stack_pop_out && instr_valid_in) |=> (flush_out && !stack_pop_out))
    else $error("prefetch not flushed");
  refused_slot_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RULE_09]
    (instr_valid_in && second_r) |=> (!stack_pop_out && !w_load_out && !icr_write_out))
    else $error("word in flush slot executed");
  flush_quiet_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RULE_09]
    flush_out |-> (!pc_load_out && !w_load_out && !icr_write_out))
    else $error("flush cycle carries strobes");
  two_cycle_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RULE_05]
    stack_pop_out |-> !$past(stack_pop_out))
    else $error("return pops twice");
  ret_cycles_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RULE_05]
    (stack_pop_out && instr_valid_in) |=> !second_r)
    else $error("return longer than two cycles");
  no_status_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RULE_10]
    !status_write_out)
    else $error("status written");

  // checks on the soft reset and its indicator
  reset_fires_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RULE_01] [RULE_02]
    is_reset_w |=> (device_reset_out && !soft_reset_indicator_n_out))
    else $error("soft reset not issued");
  reset_no_pop_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RULE_01]
    is_reset_w |=> (!stack_pop_out && !w_load_out && !icr_write_out))
    else $error("soft reset raised return strobes");
  pulse_length_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RULE_01]
    $fell(device_reset_out) |-> $past(device_reset_out, 4))
    else $error("device reset pulse too short");
  indicator_held_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RULE_02]
    !soft_reset_indicator_n_out |=> !soft_reset_indicator_n_out)
    else $error("indicator set again without reset");
  indicator_cause_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RULE_02]
    $fell(soft_reset_indicator_n_out) |-> $past(is_reset_w))
    else $error("indicator cleared without soft reset");
endmodule

/* File: test/return_and_soft_reset_ops_bench.sv */
// return_and_soft_reset_ops_bench.sv: self-checking bench for the return and soft-reset executor
// assumes: rsr_exec on one 50 MHz clock, inputs driven at the falling edge
`timescale 1ns/10ps
module return_and_soft_reset_ops_bench;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic instr_valid_in = 1'b0;
  logic [13:0] instr_in = 14'h0000;
  logic [14:0] stack_top = 15'h0000;
  logic [7:0] icr = 8'h00;
  logic pop, pcl, iwr, wld, fls, swr, ind_n, dev_rst;
  logic [14:0] pc_val;
  logic [7:0] icr_val, w_val;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  // strobes packed as pop, pc load, enable write, w load, flush, status write
  wire [5:0] strb = {pop, pcl, iwr, wld, fls, swr};
  always #10 clk_in = ~clk_in;
  rsr_exec dut_u (.clk_in(clk_in), .rst_b_in(rst_b_in), .instr_valid_in(instr_valid_in), .instr_in(instr_in),
    .top_of_return_stack_in(stack_top), .interrupt_control_register_in(icr), .stack_pop_out(pop), .pc_load_out(pcl),
    .pc_val_out(pc_val), .icr_write_out(iwr), .icr_val_out(icr_val), .w_load_out(wld), .w_val_out(w_val),
    .flush_out(fls), .status_write_out(swr), .soft_reset_indicator_n_out(ind_n), .device_reset_out(dev_rst));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // one instruction cycle with a valid word, outputs settled on return
  task automatic issue(input logic [13:0] w);
    instr_valid_in = 1'b1;
    instr_in = w;
    @(negedge clk_in);
  endtask
  task automatic idle;
    instr_valid_in = 1'b0;
    @(negedge clk_in);
  endtask
  task automatic t_reti;
    stack_top = 15'h2ABC;
    icr = 8'h15;
    issue(14'h0009);
    chk(strb, 6'h38);
    chk(pc_val, 15'h2ABC);
    chk(icr_val, 8'h95);
    issue(14'h0008);
    chk(strb, 6'h02);
    idle;
    chk(strb, 6'h00);
    $display("t_reti done");
  endtask
  task automatic t_ret;
    stack_top = 15'h4001;
    icr = 8'h00;
    issue(14'h0008);
    chk(strb, 6'h30);
    chk(pc_val, 15'h4001);
    issue(14'h0009);
    chk(strb, 6'h02);
    idle;
    $display("t_ret done");
  endtask
  // literal returns back to back, each discarding a literal return in its second cycle
  task automatic t_retl;
    logic [7:0] lits [3] = '{8'h00, 8'hFF, 8'h5A};
    for (int i = 0; i < 3; i++) begin
      stack_top = {7'h01, lits[i]};
      issue(14'h3400 | {6'h00, lits[i]});
      chk(strb, 6'h34);
      chk(w_val, lits[i]);
      chk(pc_val, {7'h01, lits[i]});
      issue(14'h3411);
      chk(strb, 6'h02);
    end
    idle;
    $display("t_retl done");
  endtask
  task automatic t_soft;
    int n;
    n = 0;
    chk(ind_n, 1'b1);
    issue(14'h0001);
    chk(strb, 6'h00);
    instr_valid_in = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (dev_rst === 1'b1) n++;
      @(negedge clk_in);
    end
    chk(n[15:0], 16'h0004);
    chk(ind_n, 1'b0);
    rst_b_in = 1'b0;
    @(negedge clk_in);
    rst_b_in = 1'b1;
    @(negedge clk_in);
    chk(ind_n, 1'b1);
    $display("t_soft done");
  endtask
  // hang guard far above the few dozen cycles the tests need
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (12) @(negedge clk_in);
    rst_b_in = 1'b1;
    t_reti;
    t_ret;
    t_retl;
    t_soft;
    tally_and_finish;
  end
endmodule
